// ### rtl/beai_map.vh
`ifndef BEAI_MAP_VH
`define BEAI_MAP_VH
// =============================================================
// Memory map
`define BEAI_BOOT_BASE     32'h0001E000
`define BEAI_BOOT_ALIAS    32'h7FFFE000
`define BEAI_BOOT_MASK     32'h00001FFF
`define BEAI_VEC_BYTES     32'h00000040
`define BEAI_CKSUM_ADDR    32'h00000014
`define BEAI_VEC_WORDS     4'h8
// =============================================================
// Timing
`define BEAI_CLK_KHZ       50000
`define BEAI_DECIDE_US     3000
`define BEAI_DECIDE_CYC    ((`BEAI_DECIDE_US * `BEAI_CLK_KHZ) / 1000)
// =============================================================
// Characters
`define BEAI_CH_SYNC       8'h3F
`define BEAI_CH_CR         8'h0D
`define BEAI_CH_LF         8'h0A
`define BEAI_CH_ESC        8'h1B
`define BEAI_CH_XON        8'h11
`define BEAI_CH_XOFF       8'h13
`define BEAI_CH_SPACE      8'h20
`define BEAI_CH_O          8'h4F
`define BEAI_CH_K          8'h4B
`define BEAI_CH_U          8'h55
`define BEAI_CH_W          8'h57
`define BEAI_CH_C          8'h43
`define BEAI_CH_E          8'h45
`define BEAI_CH_G          8'h47
`define BEAI_CH_P          8'h50
`define BEAI_CH_ZERO       8'h30
`define BEAI_UNLOCK_CODE   16'h5A5A
`define BEAI_SYNC_LEN      4'hE
`endif

// ### rtl/beai_bit_timer.v
`timescale 1ns/1ps
// =============================================================
// Bit timer: measures start-bit-to-edge span and then paces bits
module beai_bit_timer #(
    parameter W = 20
) (
    // Clock and reset
    input  wire         clk,
    input  wire         sys_rst,
    // Control
    input  wire         restart,    // Reload counter to zero
    input  wire [W-1:0] period,     // Cycles per bit
    // Outputs
    output reg          tick,       // One-cycle pulse per bit period
    output reg  [W-1:0] count       // Cycles since restart
);
    // Free counter, wraps on period for pacing
    always @(posedge clk) begin
        if (sys_rst || restart) begin
            count <= {W{1'b0}};
            tick  <= 1'b0;
        end else if (period != {W{1'b0}} && count == period - 1'b1) begin
            count <= {W{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule // beai_bit_timer

// ### rtl/beai_boot_entry.v
`timescale 1ns/1ps
`include "beai_map.vh"
// =============================================================
// Boot entry, vector check and serial programming front end
module beai_boot_entry #(
    parameter DECIDE_CYC = `BEAI_DECIDE_CYC,
    parameter BW         = 20
) (
    // Clock and reset (crystal clock, no PLL)
    input  wire        clk,
    input  wire        sys_rst,
    // Boot straps
    input  wire        prog_request_pin,      // Low requests programming
    input  wire        watchdog_timeout_flag, // Reset came from watchdog
    // Vector fetch from flash sector 0
    output reg         vec_rd,                // Read strobe
    output reg  [31:0] vec_addr,              // Byte address
    input  wire [31:0] vec_data,              // Data valid in the vec_rd cycle
    // Memory map control
    output reg         boot_alias_en,         // Boot sector at top region
    output reg         vec_overlay_en,        // Boot vectors at zero
    // Start of user code
    output reg         user_start,            // Pulse: load PC with zero
    output reg  [31:0] user_pc,               // Start address
    // Serial port 0
    input  wire        rxd,
    output reg         txd,
    // Command handler hand-off
    output reg         serial_programming_mode,
    output reg         cmd_valid,             // Pulse: command line ready
    output reg  [7:0]  cmd_letter,
    output reg         cmd_refused,           // Pulse: locked command refused
    output reg         unlocked,
    output reg  [15:0] crystal_khz,
    output reg  [BW-1:0] baud_period
);
    // =========================================================
    // States
    localparam S_WAIT   = 4'h0, S_DECIDE = 4'h1, S_SUM  = 4'h2, S_USER = 4'h3;
    localparam S_SYNC   = 4'h4, S_SYNTX  = 4'h5, S_ECHO = 4'h6, S_OK1  = 4'h7;
    localparam S_FREQ   = 4'h8, S_OK2    = 4'h9, S_CMD  = 4'hA;

    reg [3:0]    state;           // Boot sequencer state
    reg [31:0]   dcnt;            // Post-reset delay counter
    reg [31:0]   vsum;            // Running vector sum
    reg [3:0]    vidx;            // Vector word index
    reg          vpend;           // Read in flight
    reg [3:0]    tidx;            // Transmit string index
    reg [3:0]    eidx;            // Echo compare index
    reg          emiss;           // Echo mismatch seen
    reg          paused;          // Peer sent stop character
    reg [15:0]   num;             // Decimal parameter accumulator
    reg          have_letter;     // Command letter captured
    reg          in_num;          // Inside first parameter
    // Receiver
    reg [1:0]    rphase;          // 0 idle, 1 measure, 2 data
    reg [3:0]    rbit;
    reg [7:0]    rshift;
    reg [7:0]    rx_byte;
    reg          rx_stb;          // Byte received pulse
    reg          rrestart;
    reg          rx_prev;
    // Transmitter
    reg [3:0]    tbit;
    reg [9:0]    tshift;
    reg          tbusy;
    reg          tstart;
    reg [7:0]    tbyte;
    reg          trestart;
    wire         rtick;
    wire         ttick;
    wire [BW-1:0] rcount;

    // =========================================================
    // Bit pacing: receive measures span, transmit uses learnt rate
    beai_bit_timer #(.W(BW)) u_rx_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (rrestart),
        .period  (rphase == 2'h2 ? baud_period : {BW{1'b0}}),
        .tick    (rtick),
        .count   (rcount)
    );
    beai_bit_timer #(.W(BW)) u_tx_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (trestart),
        .period  (baud_period),
        .tick    (ttick),
        .count   ()
    );

    // Reply text: Synchronized CR LF, then OK CR LF
    function [7:0] sync_char;
        input [3:0] i;
        begin
            case (i)
                4'h0: sync_char = 8'h53;
                4'h1: sync_char = 8'h79;
                4'h2: sync_char = 8'h6E;
                4'h3: sync_char = 8'h63;
                4'h4: sync_char = 8'h68;
                4'h5: sync_char = 8'h72;
                4'h6: sync_char = 8'h6F;
                4'h7: sync_char = 8'h6E;
                4'h8: sync_char = 8'h69;
                4'h9: sync_char = 8'h7A;
                4'hA: sync_char = 8'h65;
                4'hB: sync_char = 8'h64;
                4'hC: sync_char = `BEAI_CH_CR;
                default: sync_char = `BEAI_CH_LF;
            endcase
        end
    endfunction
    function [7:0] ok_char;
        input [3:0] i;
        begin
            case (i)
                4'h0: ok_char = `BEAI_CH_O;
                4'h1: ok_char = `BEAI_CH_K;
                4'h2: ok_char = `BEAI_CH_CR;
                default: ok_char = `BEAI_CH_LF;
            endcase
        end
    endfunction

    // =========================================================
    // Receiver: '?' start bit to first rising edge is one bit time
    // since bit 0 of 0x3F is high; only 8N1 is supported
    always @(posedge clk) begin
        rx_prev  <= rxd;
        rx_stb   <= 1'b0;
        rrestart <= 1'b0;
        if (sys_rst) begin
            rphase  <= 2'h0;
            rbit    <= 4'h0;
            rshift  <= 8'h00;
            rx_byte <= 8'h00;
            rx_prev <= 1'b1;
            baud_period <= {BW{1'b0}};
        end else begin
            case (rphase)
                2'h0: begin
                    if (rx_prev && !rxd && serial_programming_mode) begin
                        rrestart <= 1'b1;
                        rphase   <= (baud_period == {BW{1'b0}} ||
                                     state == S_SYNC) ? 2'h1 : 2'h2;
                        rbit     <= 4'h0;
                    end
                end
                2'h1: begin
                    if (!rx_prev && rxd) begin
                        // Timer restart lags the falling edge by two cycles
                        baud_period <= rcount + {{(BW-2){1'b0}}, 2'h2};
                        rbit   <= 4'h1;
                        rshift <= 8'h80;  // Bit 0 already known high
                        rphase <= 2'h2;
                        rrestart <= 1'b1;
                    end
                end
                2'h2: begin
                    // Each tick samples one data bit; the tick after bit 7 lands in the stop bit.
                    // Samples sit two cycles into each bit: little slack for rate error
                    if (rtick) begin
                        if (rbit == 4'h8) begin
                            rphase  <= 2'h0;
                            rx_byte <= rshift;
                            rx_stb  <= 1'b1;
                        end else begin
                            rshift <= {rxd, rshift[7:1]};
                            rbit   <= rbit + 4'h1;
                        end
                    end
                end
                default: rphase <= 2'h0;
            endcase
        end
    end

    // =========================================================
    // Transmitter: 8N1 frames, holds off while paused
    always @(posedge clk) begin
        trestart <= 1'b0;
        if (sys_rst) begin
            txd <= 1'b1;
            tbusy <= 1'b0;
            tbit <= 4'h0;
            tshift <= 10'h3FF;
        end else if (!tbusy) begin
            if (tstart) begin
                tshift <= {1'b1, tbyte, 1'b0};
                tbusy  <= 1'b1;
                tbit   <= 4'h0;
                trestart <= 1'b1;
                txd    <= 1'b0;
            end
        end else if (ttick) begin
            if (tbit == 4'h9) begin
                tbusy <= 1'b0;
                txd   <= 1'b1;
            end else begin
                txd    <= tshift[tbit + 4'h1];
                tbit   <= tbit + 1'b1;
            end
        end
    end

    // =========================================================
    // Boot sequencer and line framer
    always @(posedge clk) begin
        vec_rd     <= 1'b0;
        user_start <= 1'b0;
        tstart     <= 1'b0;
        cmd_valid  <= 1'b0;
        cmd_refused <= 1'b0;
        if (sys_rst) begin
            state <= S_WAIT;
            dcnt  <= 32'h00000000;
            boot_alias_en  <= 1'b1;
            vec_overlay_en <= 1'b1;
            serial_programming_mode <= 1'b0;
            vec_addr <= 32'h00000000;
            vsum <= 32'h00000000;
            vidx <= 4'h0;
            vpend <= 1'b0;
            user_pc <= 32'h00000000;
            tidx <= 4'h0;
            eidx <= 4'h0;
            emiss <= 1'b0;
            paused <= 1'b0;
            num <= 16'h0000;
            crystal_khz <= 16'h0000;
            cmd_letter <= 8'h00;
            have_letter <= 1'b0;
            in_num <= 1'b0;
            unlocked <= 1'b0;
            tbyte <= 8'h00;
        end else begin
            // Flow control applies in every serial phase
            if (rx_stb && rx_byte == `BEAI_CH_XOFF)
                paused <= 1'b1;
            else if (rx_stb && rx_byte == `BEAI_CH_XON)
                paused <= 1'b0;
            case (state)
                S_WAIT: begin
                    // Pin floats early; external pull-up assumed
                    if (dcnt == DECIDE_CYC - 1)
                        state <= S_DECIDE;
                    else
                        dcnt <= dcnt + 32'h1;
                end
                S_DECIDE: begin
                    // Single sample; later pin changes are ignored
                    if (!prog_request_pin && !watchdog_timeout_flag) begin
                        serial_programming_mode <= 1'b1;
                        state <= S_SYNC;
                    end else begin
                        vec_overlay_en <= 1'b0;
                        state <= S_SUM;
                    end
                end
                S_SUM: begin
                    // Overlay dropped the cycle before first fetch
                    if (vpend) begin
                        vpend <= 1'b0;
                        vsum  <= vsum + vec_data;
                        vidx  <= vidx + 4'h1;
                    end else if (vidx == `BEAI_VEC_WORDS) begin
                        if (vsum == 32'h00000000) begin
                            user_pc    <= 32'h00000000;
                            user_start <= 1'b1;
                            state      <= S_USER;
                        end else begin
                            vec_overlay_en <= 1'b1;
                            serial_programming_mode <= 1'b1;
                            state <= S_SYNC;
                        end
                    end else begin
                        vec_rd   <= 1'b1;
                        vec_addr <= {26'h0, vidx, 2'h0};
                        vpend    <= 1'b1;
                    end
                end
                S_USER: state <= S_USER;
                S_SYNC: begin
                    // Host sends '?' 8N1, others dropped
                    if (rx_stb && rx_byte == `BEAI_CH_SYNC) begin
                        tidx  <= 4'h0;
                        state <= S_SYNTX;
                    end
                end
                S_SYNTX: begin
                    if (!tbusy && !tstart && !paused) begin
                        tbyte  <= sync_char(tidx);
                        tstart <= 1'b1;
                        if (tidx == `BEAI_SYNC_LEN - 4'h1) begin
                            eidx  <= 4'h0;
                            emiss <= 1'b0;
                            state <= S_ECHO;
                        end else
                            tidx <= tidx + 4'h1;
                    end
                end
                S_ECHO: begin
                    if (rx_stb && rx_byte != `BEAI_CH_XON && rx_byte != `BEAI_CH_XOFF) begin
                        if (eidx == `BEAI_SYNC_LEN - 4'h1) begin
                            tidx <= 4'h0;
                            // Mismatch returns to waiting
                            state <= (emiss || rx_byte != sync_char(eidx)) ? S_SYNC : S_OK1;
                        end else begin
                            if (rx_byte != sync_char(eidx))
                                emiss <= 1'b1;
                            eidx <= eidx + 4'h1;
                        end
                    end
                end
                S_OK1, S_OK2: begin
                    if (!tbusy && !tstart && !paused) begin
                        tbyte  <= ok_char(tidx);
                        tstart <= 1'b1;
                        tidx   <= tidx + 4'h1;
                        if (tidx == 4'h3) begin
                            num   <= 16'h0000;
                            state <= (state == S_OK1) ? S_FREQ : S_CMD;
                        end
                    end
                end
                S_FREQ: begin
                    // Decimal kHz up to CR or LF
                    if (rx_stb) begin
                        if (rx_byte == `BEAI_CH_CR || rx_byte == `BEAI_CH_LF) begin
                            crystal_khz <= num;
                            tidx  <= 4'h0;
                            state <= S_OK2;
                        end else if (rx_byte >= `BEAI_CH_ZERO && rx_byte <= 8'h39)
                            num <= num * 16'hA + {8'h00, rx_byte - `BEAI_CH_ZERO};
                    end
                end
                S_CMD: begin
                    // Letter, space, decimal parameter, terminator
                    if (rx_stb) begin
                        if (rx_byte == `BEAI_CH_ESC) begin
                            have_letter <= 1'b0;
                            in_num <= 1'b0;
                            num <= 16'h0000;
                        end else if (rx_byte == `BEAI_CH_CR || rx_byte == `BEAI_CH_LF) begin
                            // Blank lines drop silently
                            if (have_letter) begin
                                if ((cmd_letter == `BEAI_CH_W || cmd_letter == `BEAI_CH_C ||
                                     cmd_letter == `BEAI_CH_E || cmd_letter == `BEAI_CH_G ||
                                     cmd_letter == `BEAI_CH_P) && !unlocked)
                                    cmd_refused <= 1'b1;
                                else
                                    cmd_valid <= 1'b1;
                                if (cmd_letter == `BEAI_CH_U && num == `BEAI_UNLOCK_CODE)
                                    unlocked <= 1'b1;
                            end
                            have_letter <= 1'b0;
                            in_num <= 1'b0;
                            num <= 16'h0000;
                        end else if (rx_byte == `BEAI_CH_XON || rx_byte == `BEAI_CH_XOFF) begin
                            have_letter <= have_letter;
                        end else if (!have_letter) begin
                            cmd_letter  <= rx_byte;
                            have_letter <= 1'b1;
                        end else if (rx_byte == `BEAI_CH_SPACE) begin
                            in_num <= ~in_num & (num == 16'h0000);
                        end else if (in_num && rx_byte >= `BEAI_CH_ZERO && rx_byte <= 8'h39)
                            num <= num * 16'hA + {8'h00, rx_byte - `BEAI_CH_ZERO};
                    end
                end
                default: state <= S_WAIT;
            endcase
        end
    end
    // Clock is the crystal directly; 10 MHz floor keeps bit count wide
endmodule // beai_boot_entry

// ### verif/beai_boot_props.sv
`timescale 1ns/1ps
// ============================================================
// Boot entry checker, ports of the top module only
module beai_boot_props #(
    parameter DECIDE_CYC = 20,
    parameter BW         = 20
) (
    // Clock and reset
    input wire logic          clk,
    input wire logic          sys_rst,
    // Vector fetch and memory map
    input wire logic          vec_rd,
    input wire logic [31:0]   vec_addr,
    input wire logic          boot_alias_en,
    input wire logic          vec_overlay_en,
    input wire logic          user_start,
    input wire logic [31:0]   user_pc,
    // Serial line and hand-off
    input wire logic          txd,
    input wire logic          serial_programming_mode,
    input wire logic          cmd_valid,
    input wire logic          cmd_refused,
    input wire logic          unlocked,
    input wire logic [BW-1:0] baud_period
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Cycles since release; saturates so a long session never wraps
    logic [31:0] since;
    always @(posedge clk) begin
        if (sys_rst) since <= 32'h0;
        else if (since != 32'hFFFFFFFF) since <= since + 32'h1;
    end
    a_reset_map: assert property ($fell(sys_rst) |-> boot_alias_en && vec_overlay_en && txd)
        else $error("map or line not in reset state");
    a_alias_kept: assert property (boot_alias_en)
        else $error("boot alias dropped");
    a_read_unmapped: assert property (vec_rd |-> !vec_overlay_en && vec_addr < 32'h20 && vec_addr[1:0] == 2'h0)
        else $error("vector read with overlay or bad address");
    a_decide_first: assert property (vec_rd || serial_programming_mode |-> since >= DECIDE_CYC - 2)
        else $error("activity before the boot decision");
    a_start_zero: assert property (user_start |-> user_pc == 32'h0 && !vec_overlay_en ##1 !user_start)
        else $error("user start not a clean pulse at zero");
    a_tx_after_baud: assert property ($fell(txd) |-> baud_period != '0)
        else $error("transmit before baud measured");
    a_refuse_locked: assert property (cmd_refused |-> !unlocked && serial_programming_mode)
        else $error("refusal while unlocked");
    a_unlock_held: assert property (unlocked |=> unlocked)
        else $error("unlock lost in session");
    a_mode_held: assert property (serial_programming_mode |=> serial_programming_mode)
        else $error("programming mode dropped");
    a_cmd_in_mode: assert property (cmd_valid |-> serial_programming_mode ##1 !cmd_valid)
        else $error("command outside handler or not a pulse");
endmodule // beai_boot_props

bind beai_boot_entry beai_boot_props #(.DECIDE_CYC(DECIDE_CYC), .BW(BW)) u_props (
    .clk(clk), .sys_rst(sys_rst), .vec_rd(vec_rd), .vec_addr(vec_addr),
    .boot_alias_en(boot_alias_en), .vec_overlay_en(vec_overlay_en),
    .user_start(user_start), .user_pc(user_pc), .txd(txd),
    .serial_programming_mode(serial_programming_mode), .cmd_valid(cmd_valid),
    .cmd_refused(cmd_refused), .unlocked(unlocked), .baud_period(baud_period));

// ### verif/beai_host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host side of the programming link, 8N1
module beai_host_model #(
    parameter int BIT = 16  // Clocks per bit
) (
    // Clock
    input wire logic clk,
    // Serial line
    output logic     rxd,   // Device receive line
    input wire logic txd    // Device transmit line
);
    initial rxd = 1'b1;  // Idle mark level
    // One byte, LSB first, no parity, one stop bit
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 rxd = f[i];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask
    // Whole line, as typed by the host
    task automatic send_str(input string s);
        foreach (s[i]) send_byte(s[i]);
    endtask
    // Mid-bit sampling; stays unknown if no start bit shows
    task automatic recv_byte(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'hXX;
        while (txd !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        if (n < 40000) begin
            repeat (BIT / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(negedge clk);
                b[i] = txd;
            end
            repeat (BIT) @(negedge clk);
        end
    endtask
endmodule // beai_host_model

// ### verif/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    // ============================================================
    // Setup; decision delay shortened for simulation
    localparam int    BIT = 16;
    localparam int    DEC = 20;
    localparam string SYN = "Synchronized\r\n";
    logic        clk, sys_rst, req_pin, wdt_flag;
    logic [31:0] vec_data;
    logic [31:0] vecs [8];    // Sector 0 vector words
    logic [7:0]  last_letter; // Letter of last handed-off command
    int          n_mismatch, checked, n_start, n_ref;
    wire         rxd, txd, vec_rd, boot_alias_en, vec_overlay_en, user_start;
    wire         prog_mode, cmd_valid, cmd_refused, unlocked;
    wire [31:0]  vec_addr, user_pc;
    wire [7:0]   cmd_letter;
    wire [15:0]  crystal_khz;
    wire [19:0]  baud_period;
    beai_boot_entry #(.DECIDE_CYC(DEC), .BW(20)) DUT (
        .clk(clk), .sys_rst(sys_rst), .prog_request_pin(req_pin),
        .watchdog_timeout_flag(wdt_flag), .vec_rd(vec_rd), .vec_addr(vec_addr),
        .vec_data(vec_data), .boot_alias_en(boot_alias_en), .vec_overlay_en(vec_overlay_en),
        .user_start(user_start), .user_pc(user_pc), .rxd(rxd), .txd(txd),
        .serial_programming_mode(prog_mode), .cmd_valid(cmd_valid), .cmd_letter(cmd_letter),
        .cmd_refused(cmd_refused), .unlocked(unlocked), .crystal_khz(crystal_khz),
        .baud_period(baud_period));
    beai_host_model #(.BIT(BIT)) hm (.clk(clk), .rxd(rxd), .txd(txd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Flash answers within the strobe cycle; the sequencer sums at its end
    assign vec_data = vecs[vec_addr[4:2]];
    // Pulse monitors
    always @(posedge clk) begin
        if (user_start) n_start++;
        if (cmd_refused) n_ref++;
        if (cmd_valid) last_letter = cmd_letter;
    end
    task automatic do_reset(input logic pin, input logic flag, input logic good);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 8; i++) begin
            vecs[i] = 32'h12345678 + 32'(i);
            if (i != 5) s = s + vecs[i];
        end
        vecs[5] = good ? -s : s;
        @(posedge clk);
        #1 sys_rst = 1'b1;
        req_pin = pin;  // Always a defined level
        wdt_flag = flag;
        n_start = 0;
        n_ref = 0;
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        `CHK({boot_alias_en, vec_overlay_en, txd, user_start}, 4'hE)
    endtask
    task automatic expect_str(input string s);
        logic [7:0] b;
        foreach (s[i]) begin
            hm.recv_byte(b);
            `CHK(b, s[i])
        end
    endtask
    task automatic t_user();
        do_reset(1'b1, 1'b0, 1'b1);
        repeat (DEC + 4) @(posedge clk);
        #1 req_pin = 1'b0;  // Late request must not count
        repeat (60) @(posedge clk);
        `CHK(n_start, 1)
        `CHK(user_pc, 32'h0)
        `CHK(vec_overlay_en, 1'b0)
        do_reset(1'b0, 1'b1, 1'b1);
        repeat (DEC + 60) @(posedge clk);
        `CHK(n_start, 1)
    endtask
    task automatic t_sync();
        do_reset(1'b1, 1'b0, 1'b0);
        repeat (DEC + 60) @(posedge clk);
        `CHK(n_start, 0)
        `CHK(vec_overlay_en, 1'b1)
        hm.send_byte(8'h41);  // Stray character first
        fork hm.send_byte(8'h3F); expect_str(SYN); join
        `CHK(baud_period, 20'(BIT))
        hm.send_str("Synchronized\r\r");  // Echo wrong in last place
        fork hm.send_byte(8'h3F); expect_str(SYN); join
        fork hm.send_str(SYN); expect_str("OK\r\n"); join
        fork hm.send_str("10000\r\n"); expect_str("OK\r\n"); join
        `CHK(crystal_khz, 16'h2710)
        `CHK(prog_mode, 1'b1)
    endtask
    task automatic t_cmds();
        hm.send_str("J\r\n");
        repeat (BIT) @(posedge clk);
        `CHK(last_letter, 8'h4A)
        hm.send_str("E 0 1\r\n");
        repeat (BIT) @(posedge clk);
        `CHK(n_ref, 1)
        `CHK(unlocked, 1'b0)
        hm.send_str("\r\n\nU 23130\r\n");
        repeat (BIT) @(posedge clk);
        `CHK(unlocked, 1'b1)
        hm.send_str("E 0 1\n");
        repeat (BIT) @(posedge clk);
        `CHK(last_letter, 8'h45)
        hm.send_str("G 0 A");
        hm.send_byte(8'h1B);  // Abort the half-typed line
        hm.send_str("K\r");
        repeat (BIT) @(posedge clk);
        `CHK(last_letter, 8'h4B)
        `CHK(n_ref, 1)
    endtask
    task automatic t_request();
        do_reset(1'b0, 1'b0, 1'b1);
        repeat (DEC + 60) @(posedge clk);
        `CHK(n_start, 0)
        `CHK(unlocked, 1'b0)
        hm.send_byte(8'h13);  // Stop character holds the reply back
        hm.send_byte(8'h3F);
        repeat (4 * BIT) @(posedge clk);
        `CHK(txd, 1'b1)
        fork hm.send_byte(8'h11); expect_str(SYN); join
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        req_pin = 1'b1;
        wdt_flag = 1'b0;
        t_user();
        t_sync();
        t_cmds();
        t_request();
        give_verdict();
    end
    // Hang guard, well beyond the expected run
    initial begin
        #1000000;
        n_mismatch++;
        give_verdict();
    end
endmodule // testbench
